// ==== design/lrx_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the receive output stage
`ifndef LRX_CFG_SVH
`define LRX_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LRX_OFF_CTRL 8'h00
`define LRX_OFF_STATUS 8'h04
`define LRX_OFF_CNT_CLR 8'h08
`define LRX_OFF_CNT_BASE 8'h20
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LRX_CTRL_W 5
`define LRX_CTRL_RESET 5'h18
`define LRX_STAT_LOS_LSB 0
`define LRX_STAT_OVF_LSB 8
`define LRX_STAT_FBK_LSB 16
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LRX_ACLK_NS 8
`define LRX_MCLK_NS 160
`define LRX_MCLK_HALF_CYC (`LRX_MCLK_NS / `LRX_ACLK_NS / 2)
`define LRX_RESP_OKAY 2'h0
`define LRX_RESP_SLVERR 2'h2
`endif

// ==== design/lrx_output_stage.sv ====
// Eight-channel receive output stage with AXI4-Lite control
`include "lrx_cfg.svh"

// Function
// - In hardware mode one enable pin switches all eight receivers.
// - Receivers default on; drive the enable pin low to turn them off.
// - Loss-of-signal output goes high for at least one receive clock cycle.
// - Loss-of-signal output stays high until the loss condition clears.
// - Each channel outputs a clock recovered from its line data.
// - Absent or high-impedance line keeps clock running from internal master.
// - Data outputs update on rising or falling clock edge as selected.
// - Edge selection is one global setting for all channels.
// - Dual-rail: negative pulses appear on the negative-rail output.
// - Single-rail: negative rail shows violations or overflow, globally selected.
// - Violation mode: indicator high at least one clock per violation.
// - Violation mode: indicator stays high while violations continue.
// - Overflow mode: indicator high once the violation counter saturates.
// - Overflow mode: indicator stays high until the counter is reset.
// - Dual-rail: positive pulses appear on the positive-rail output.
// - Single-rail: positive rail carries decoded NRZ data.
// - Hardware mode, muting high and loss: both data outputs forced low.
module lrx_output_stage import lrx_pkg::*; #(
    parameter int CHANNELS = 8,
    parameter int CNT_W = 16,
    parameter int EXZ_LIMIT = 8,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lrx_line_t [CHANNELS-1:0] line_in,
    input wire logic receivers_enable_input,
    input wire logic receive_muting_control,
    output lrx_out_t [CHANNELS-1:0] rx_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int MCLK_HALF = `LRX_MCLK_HALF_CYC;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [4:0] EXZ_LAST = 5'(EXZ_LIMIT - 1);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic cnt_hit(input logic [ADDR_W-1:0] a, output int ch);
        int idx;
        idx = (int'(a) - int'(`LRX_OFF_CNT_BASE)) / 4;
        ch = idx;
        return (a >= ADDR_W'(`LRX_OFF_CNT_BASE)) && (a[1:0] == 2'h0) && (idx < CHANNELS);
    endfunction : cnt_hit

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    lrx_line_t [CHANNELS-1:0] sync1, sync2;
    logic [CHANNELS-1:0] line_clk_d;
    logic [1:0] pin1, pin2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            line_clk_d <= '0;
            pin1 <= 2'h3;
            pin2 <= 2'h3;
        end else begin
            sync1 <= line_in;
            sync2 <= sync1;
            for (int c = 0; c < CHANNELS; c++) begin
                line_clk_d[c] <= sync2[c].clk;
            end
            pin1 <= {receivers_enable_input, receive_muting_control};
            pin2 <= pin1;
        end
    end

    // ------------------------------------------------------------------
    // Internal master clock for fallback timing
    // ------------------------------------------------------------------
    logic [7:0] mclk_cnt, next_mclk_cnt;
    logic mclk, next_mclk;

    always_comb begin
        next_mclk_cnt = mclk_cnt + 8'h01;
        next_mclk = mclk;
        if (mclk_cnt == 8'(MCLK_HALF - 1)) begin
            next_mclk_cnt = 8'h00;
            next_mclk = !mclk;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mclk_cnt <= 8'h00;
            mclk <= 1'b0;
        end else begin
            mclk_cnt <= next_mclk_cnt;
            mclk <= next_mclk;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    lrx_ctrl_t ctrl, next_ctrl;
    logic [CHANNELS-1:0] cnt_clr;
    logic rx_en, mute_en;

    assign rx_en = ctrl.hw_mode ? pin2[1] : ctrl.host_rx_en;
    assign mute_en = ctrl.hw_mode & pin2[0];

    // ------------------------------------------------------------------
    // Per-channel receive path
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0] rclk, next_rclk, upd, next_upd, fbk, next_fbk;
    logic [CHANNELS-1:0] cap_pos, next_cap_pos, cap_neg, next_cap_neg;
    logic [CHANNELS-1:0] last_pos, next_last_pos, seen, next_seen;
    logic [CHANNELS-1:0] viol_pend, next_viol_pend;
    logic [4:0] zeros [CHANNELS];
    logic [4:0] next_zeros [CHANNELS];
    logic [CNT_W-1:0] vcnt [CHANNELS];
    logic [CNT_W-1:0] next_vcnt [CHANNELS];
    lrx_out_t [CHANNELS-1:0] next_out;

    always_comb begin
        logic active, rise, src, pulse, bpv, exz, viol, los_c, ovf;
        active = 1'b0;
        rise = 1'b0;
        src = 1'b0;
        pulse = 1'b0;
        bpv = 1'b0;
        exz = 1'b0;
        viol = 1'b0;
        los_c = 1'b0;
        ovf = 1'b0;
        for (int c = 0; c < CHANNELS; c++) begin
            active = rx_en & !sync2[c].los & !sync2[c].hiz;
            los_c = rx_en & (sync2[c].los | sync2[c].hiz);
            rise = active & sync2[c].clk & !line_clk_d[c];
            // Recovered clock, else master clock so the framer never stalls
            src = active ? sync2[c].clk : mclk;
            next_rclk[c] = src;
            next_fbk[c] = !active;
            next_upd[c] = (rclk[c] != rx_out[c].clk) && (rclk[c] == !ctrl.edge_fall);
            pulse = sync2[c].pos | sync2[c].neg;
            bpv = rise & ((sync2[c].pos & sync2[c].neg)
                | (pulse & seen[c] & (sync2[c].pos == last_pos[c])));
            exz = rise & !pulse & (zeros[c] == EXZ_LAST);
            viol = bpv | exz;
            next_cap_pos[c] = cap_pos[c];
            next_cap_neg[c] = cap_neg[c];
            next_last_pos[c] = last_pos[c];
            next_seen[c] = seen[c];
            next_zeros[c] = zeros[c];
            if (!active) begin
                next_cap_pos[c] = 1'b0;
                next_cap_neg[c] = 1'b0;
                next_seen[c] = 1'b0;
                next_zeros[c] = 5'h00;
            end else if (rise) begin
                next_cap_pos[c] = sync2[c].pos;
                next_cap_neg[c] = sync2[c].neg;
                if (pulse) begin
                    next_last_pos[c] = sync2[c].pos;
                    next_seen[c] = 1'b1;
                    next_zeros[c] = 5'h00;
                end else if (zeros[c] != EXZ_LAST) begin
                    next_zeros[c] = zeros[c] + 5'h01;
                end
            end
            // New violation wins over the consume on an update edge
            next_viol_pend[c] = (viol_pend[c] & !upd[c]) | viol;
            if (cnt_clr[c]) begin
                next_vcnt[c] = CNT_W'(viol);
            end else if (viol && vcnt[c] != CNT_MAX) begin
                next_vcnt[c] = vcnt[c] + CNT_W'(1);
            end else begin
                next_vcnt[c] = vcnt[c];
            end
            ovf = (vcnt[c] == CNT_MAX);
            next_out[c] = rx_out[c];
            next_out[c].clk = rclk[c];
            // Data and flags follow one aclk after the selected edge for hold
            if (upd[c]) begin
                next_out[c].los = los_c;
                if (ctrl.single_rail) begin
                    next_out[c].pos = cap_pos[c] | cap_neg[c];
                    next_out[c].neg = ctrl.ovf_sel ? ovf : viol_pend[c];
                end else begin
                    next_out[c].pos = cap_pos[c];
                    next_out[c].neg = cap_neg[c];
                end
                if (mute_en && los_c) begin
                    next_out[c].pos = 1'b0;
                    next_out[c].neg = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rclk <= '0;
            upd <= '0;
            fbk <= '0;
            cap_pos <= '0;
            cap_neg <= '0;
            last_pos <= '0;
            seen <= '0;
            viol_pend <= '0;
            rx_out <= '0;
            for (int c = 0; c < CHANNELS; c++) begin
                zeros[c] <= 5'h00;
                vcnt[c] <= '0;
            end
        end else begin
            rclk <= next_rclk;
            upd <= next_upd;
            fbk <= next_fbk;
            cap_pos <= next_cap_pos;
            cap_neg <= next_cap_neg;
            last_pos <= next_last_pos;
            seen <= next_seen;
            viol_pend <= next_viol_pend;
            rx_out <= next_out;
            for (int c = 0; c < CHANNELS; c++) begin
                zeros[c] <= next_zeros[c];
                vcnt[c] <= next_vcnt[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [CHANNELS-1:0] next_cnt_clr;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        int ch;
        logic [31:0] stat;
        ch = 0;
        stat = '0;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_ctrl = ctrl;
        next_cnt_clr = '0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_held && w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `LRX_RESP_OKAY;
            if (aw_addr == ADDR_W'(`LRX_OFF_CTRL)) begin
                if (w_lane0) begin
                    next_ctrl = lrx_ctrl_t'(w_data[`LRX_CTRL_W-1:0]);
                end
            end else if (aw_addr == ADDR_W'(`LRX_OFF_CNT_CLR)) begin
                if (w_lane0) begin
                    next_cnt_clr = w_data[CHANNELS-1:0];
                end
            end else if (!(aw_addr == ADDR_W'(`LRX_OFF_STATUS) || cnt_hit(aw_addr, ch))) begin
                next_bresp = `LRX_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        for (int c = 0; c < CHANNELS; c++) begin
            stat[`LRX_STAT_LOS_LSB + c] = rx_out[c].los;
            stat[`LRX_STAT_OVF_LSB + c] = (vcnt[c] == CNT_MAX);
            stat[`LRX_STAT_FBK_LSB + c] = fbk[c];
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `LRX_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr == ADDR_W'(`LRX_OFF_CTRL)) begin
                next_rdata = 32'(ctrl);
            end else if (s_axi_araddr == ADDR_W'(`LRX_OFF_STATUS)) begin
                next_rdata = stat;
            end else if (s_axi_araddr == ADDR_W'(`LRX_OFF_CNT_CLR)) begin
                next_rdata = 32'h0000_0000;
            end else if (cnt_hit(s_axi_araddr, ch)) begin
                next_rdata = 32'(vcnt[ch]);
            end else begin
                next_rresp = `LRX_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            ctrl <= lrx_ctrl_t'(`LRX_CTRL_RESET);
            cnt_clr <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            ctrl <= next_ctrl;
            cnt_clr <= next_cnt_clr;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule : lrx_output_stage

// ==== design/lrx_pkg.sv ====
// Types shared by the receive output stage
package lrx_pkg;
    // Global control, bit 4 down to bit 0
    typedef struct packed {
        logic hw_mode;
        logic host_rx_en;
        logic ovf_sel;
        logic edge_fall;
        logic single_rail;
    } lrx_ctrl_t;

    // One channel as seen from clock recovery and slicer
    typedef struct packed {
        logic clk;
        logic pos;
        logic neg;
        logic los;
        logic hiz;
    } lrx_line_t;

    // One channel toward the framer
    typedef struct packed {
        logic clk;
        logic pos;
        logic neg;
        logic los;
    } lrx_out_t;
endpackage : lrx_pkg

// ==== sim/lrx_line_model.sv ====
// Line-side source: recovered clock and sliced pulses per channel
module lrx_line_model import lrx_pkg::*; (
    input wire logic viol,
    input wire logic quiet,
    input wire logic [7:0] los_ch,
    input wire logic [7:0] hiz_ch,
    output lrx_line_t [7:0] line
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Per-channel bit engine, 160 ns per bit
    // ----------------------------------------
    localparam logic [7:0] PAT = 8'hb2;
    for (genvar c = 0; c < 8; c++) begin : g_ch
        initial begin
            logic m;
            int i;
            m = 1'b0;
            i = 0;
            line[c] = '0;
            #(c * 7 + 3);
            forever begin
                line[c].los = los_ch[c];
                line[c].hiz = hiz_ch[c];
                if (los_ch[c] || hiz_ch[c]) begin
                    // Dead line: clock still, slicer chatters
                    line[c].clk = 1'b0;
                    line[c].pos = ~line[c].pos;
                    line[c].neg = line[c].pos;
                    #160;
                end else begin
                    // Marks alternate unless violations are asked for
                    m = PAT[i % 8] ? (viol | ~m) : m;
                    // Quiet gives long zero runs
                    line[c].pos = PAT[i % 8] & m & ~quiet;
                    line[c].neg = PAT[i % 8] & ~m & ~quiet;
                    i++;
                    #40 line[c].clk = 1'b1;
                    #80 line[c].clk = 1'b0;
                    #40;
                end
            end
        end
    end
endmodule : lrx_line_model

// ==== sim/lrx_output_stage_monitor.sv ====
// Port-level checks for the receive output stage
module lrx_output_stage_monitor import lrx_pkg::*; #(
    parameter int CHANNELS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lrx_line_t [CHANNELS-1:0] line_in,
    input wire logic receivers_enable_input,
    input wire lrx_out_t [CHANNELS-1:0] rx_out,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Stall counter on channel 0 clock
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] still;
    logic [7:0] next_still;
    logic clk_q;
    logic next_clk_q;
    always_comb begin
        next_clk_q = rx_out[0].clk;
        next_still = (!aresetn || rx_out[0].clk != clk_q) ? 8'h00 : still + 8'h01;
    end
    always_ff @(posedge aclk) begin
        clk_q <= next_clk_q;
        still <= next_still;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Limit allows a source switch between line and master clock
    a_clk_runs: assert property (still < 8'h28)
        else $error("receive clock stalled");
    a_los_rise: assert property ($rose(line_in[0].los) && receivers_enable_input
        |-> ##[3:40] rx_out[0].los) else $error("loss flag not raised");
    a_los_min: assert property ($rose(rx_out[0].los) |=> rx_out[0].los [*8])
        else $error("loss flag too short");
    a_los_hold: assert property (rx_out[0].los && line_in[0].los && $past(line_in[0].los, 4)
        && receivers_enable_input |=> rx_out[0].los) else $error("loss flag dropped early");
    a_data_edge: assert property ($changed({rx_out[0].pos, rx_out[0].neg, rx_out[0].los})
        |-> $past(rx_out[0].clk) != $past(rx_out[0].clk, 2)) else $error("data off edge");
    a_mute_low: assert property (rx_out[0].los |-> !rx_out[0].pos)
        else $error("data not forced low");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answer pending");
    a_b_answer: assert property ($fell(s_axi_awready) |-> ##[0:3] s_axi_bvalid)
        else $error("write answer late");
endmodule : lrx_output_stage_monitor

bind lrx_output_stage lrx_output_stage_monitor #(.CHANNELS(CHANNELS)) u_mon (
    .aclk(aclk), .aresetn(aresetn), .line_in(line_in),
    .receivers_enable_input(receivers_enable_input), .rx_out(rx_out),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// ==== sim/tb.sv ====
// Self-checking bench for the receive output stage
`include "lrx_cfg.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, a); end end
module tb import lrx_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals and table
    // ----------------------------------------
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} lrx_row_t;
    logic aclk, aresetn, receivers_enable_input, receive_muting_control, viol, edge_fall, quiet;
    logic [7:0] los_ch, hiz_ch, s_axi_awaddr, s_axi_araddr;
    lrx_line_t [7:0] line_in;
    lrx_out_t [7:0] rx_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count, comparisons;
    lrx_row_t rows [7] = '{
        '{`LRX_OFF_CTRL, 32'hffffffff, `LRX_RESP_OKAY, 32'h1f},
        '{`LRX_OFF_STATUS, 32'hffffffff, `LRX_RESP_OKAY, 32'h0},
        '{`LRX_OFF_CNT_CLR, 32'hff, `LRX_RESP_OKAY, 32'h0},
        '{8'h10, 32'h1, `LRX_RESP_SLVERR, 32'h0},
        '{8'h40, 32'h1, `LRX_RESP_SLVERR, 32'h0},
        '{8'hfc, 32'h1, `LRX_RESP_SLVERR, 32'h0},
        '{`LRX_OFF_CTRL, 32'h18, `LRX_RESP_OKAY, 32'h18}};
    lrx_output_stage #(.CNT_W(4)) uut (
        .aclk(aclk), .aresetn(aresetn), .line_in(line_in), .rx_out(rx_out),
        .receivers_enable_input(receivers_enable_input),
        .receive_muting_control(receive_muting_control),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    lrx_line_model far (.viol(viol), .quiet(quiet), .los_ch(los_ch), .hiz_ch(hiz_ch), .line(line_in));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        resp = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask : xfer
    task automatic ctl(input logic [4:0] v);
        xfer(1'b1, `LRX_OFF_CTRL, {27'h0, v});
        edge_fall = v[1];
    endtask : ctl
    // Framer view: ones over 32 selected edges; data must move one aclk after that edge
    task automatic lchk(input int c, input int ep, input int en, input int el);
        logic prev, prev2;
        logic [2:0] pd;
        int n = 0, k = 0, np = 0, nn = 0, nl = 0, nb = 0;
        repeat (60) @(posedge aclk);
        @(negedge aclk);
        prev2 = rx_out[c].clk;
        @(negedge aclk);
        prev = rx_out[c].clk;
        pd = {rx_out[c].pos, rx_out[c].neg, rx_out[c].los};
        while (n < 32 && k < 2000) begin
            @(negedge aclk);
            k++;
            if ({rx_out[c].pos, rx_out[c].neg, rx_out[c].los} !== pd
                && (prev === prev2 || prev !== !edge_fall)) nb++;
            if (rx_out[c].clk !== prev && rx_out[c].clk === !edge_fall) begin
                n++;
                np += rx_out[c].pos;
                nn += rx_out[c].neg;
                nl += rx_out[c].los;
            end
            prev2 = prev;
            prev = rx_out[c].clk;
            pd = {rx_out[c].pos, rx_out[c].neg, rx_out[c].los};
        end
        `CHK("edges", 32, n)
        `CHK("pos ones", ep, np)
        `CHK("neg ones", en, nn)
        `CHK("los ones", el, nl)
        `CHK("off edge", 0, nb)
    endtask : lchk
    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        #600000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {aresetn, receive_muting_control, viol, quiet, edge_fall, los_ch, hiz_ch} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        receivers_enable_input = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        xfer(1'b0, `LRX_OFF_CTRL, 0);
        `CHK("ctrl reset", 32'h18, rd)
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].d);
            `CHK("write resp", rows[i].r, resp)
            xfer(1'b0, rows[i].a, 0);
            `CHK("read resp", rows[i].r, resp)
            `CHK("read data", rows[i].q, rd)
        end
        for (int e = 0; e < 2; e++) begin
            ctl(e ? 5'h1a : 5'h18);
            for (int c = 0; c < 8; c++) lchk(c, 8, 8, 0);
        end
        ctl(5'h19);
        lchk(0, 16, 0, 0);
        // Long zero run flags every bit once saturated
        quiet <= 1'b1;
        repeat (200) @(posedge aclk);
        lchk(0, 0, 32, 0);
        quiet <= 1'b0;
        viol <= 1'b1;
        lchk(0, 16, 16, 0);
        ctl(5'h1d);
        lchk(0, 16, 32, 0);
        xfer(1'b0, `LRX_OFF_STATUS, 0);
        `CHK("status ovf", 32'hff00, rd)
        xfer(1'b0, `LRX_OFF_CNT_BASE, 0);
        `CHK("count sat", 32'hf, rd)
        viol <= 1'b0;
        repeat (100) @(posedge aclk);
        xfer(1'b1, `LRX_OFF_CNT_CLR, 1);
        lchk(0, 16, 0, 0);
        lchk(1, 16, 32, 0);
        xfer(1'b0, `LRX_OFF_CNT_BASE, 0);
        `CHK("count clear", 32'h0, rd)
        ctl(5'h18);
        receivers_enable_input <= 1'b0;
        lchk(0, 0, 0, 0);
        xfer(1'b0, `LRX_OFF_STATUS, 0);
        `CHK("status off", 32'hfffe00, rd)
        ctl(5'h08);
        lchk(0, 8, 8, 0);
        ctl(5'h00);
        lchk(0, 0, 0, 0);
        ctl(5'h18);
        receivers_enable_input <= 1'b1;
        receive_muting_control <= 1'b1;
        los_ch <= 8'h01;
        lchk(0, 0, 0, 32);
        hiz_ch <= 8'h02;
        lchk(1, 0, 0, 32);
        receive_muting_control <= 1'b0;
        lchk(0, 0, 0, 32);
        los_ch <= 8'h00;
        hiz_ch <= 8'h00;
        lchk(0, 8, 8, 0);
        lchk(1, 8, 8, 0);
        // Mid-run reset brings back the default control word
        ctl(5'h08);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("reset out", 32'h0, rx_out)
        aresetn <= 1'b1;
        xfer(1'b0, `LRX_OFF_CTRL, 0);
        `CHK("ctrl again", 32'h18, rd)
        report_and_stop();
    end
endmodule : tb
